// ### c16sc_socket_ctrl.sv
// Purpose: control-signal handling of a 16-bit card socket
// Assumes: all pin inputs synchronous to I_CLOCK; one socket plus one
//          external audio source to combine with
// Notes: strobes and byte enables are active low on the card side
//
// What this block does
// - decode battery lines into good, weak, dead
// - first battery line is ring for modems
// - second line is speaker only in I/O mode
// - combine socket audio onto one output pin
// - card grounds detect lines; both reported as status
// - first enable even bytes, second odd bytes
// - assert read strobe during host I/O reads
// - read strobe is DMA write strobe, card-to-host
// - drive write strobe low on host I/O writes
// - write strobe moves words host-to-card in DMA
`timescale 1ns/100ps
module c16sc_socket_ctrl
   import c16sc_pkg::*;
(
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   // configuration from the controller
   input wire logic I_IO_MODE,
   input wire logic I_MODEM_CARD,
   input wire logic I_DMA_REQ_SEL,
   // card side inputs
   input wire logic I_BATTERY_DETECT_FIRST,
   input wire logic I_BATTERY_DETECT_SECOND,
   input wire logic I_CARD_DETECT_FIRST_N,
   input wire logic I_CARD_DETECT_SECOND_N,
   input wire logic I_INPUT_ACKNOWLEDGE_N,
   input wire logic I_WAIT_N,
   // audio of the other socket
   input wire logic I_OTHER_AUDIO,
   // cycle request from the controller
   input wire logic I_CYC_START,
   input wire logic [1:0] I_CYC_KIND,
   input wire logic I_CYC_ADDR0,
   input wire logic I_CYC_WIDE,
   // card side outputs
   output logic O_EVEN_BYTE_ENABLE_N,
   output logic O_ODD_BYTE_ENABLE_N,
   output logic O_IO_READ_STROBE_N,
   output logic O_IO_WRITE_STROBE_N,
   output logic O_COMBINED_AUDIO_OUT,
   // status to the controller
   output logic [1:0] O_BATT_STATUS,
   output logic O_RING_INDICATE,
   output logic O_CARD_DETECT_FIRST_N,
   output logic O_CARD_DETECT_SECOND_N,
   output logic O_CARD_PRESENT,
   output logic O_DMA_REQ,
   output logic O_INPUT_ACK,
   output logic O_CYC_BUSY,
   output logic O_CYC_DONE
);

   // -------------------------------------------------------------
   // status decode
   // -------------------------------------------------------------
   logic [1:0] batt_reg, batt_next;      // battery condition
   logic ring_reg, ring_next;            // ring indication
   logic audio_reg, audio_next;          // combined speaker output
   logic cd1_reg, cd1_next;              // card detect first, raw
   logic cd2_reg, cd2_next;              // card detect second, raw
   logic present_reg, present_next;      // both detect lines low
   logic dreq_reg, dreq_next;            // dma request from card
   logic iack_reg, iack_next;            // input acknowledge seen

   // battery decode from the two detect lines
   function automatic logic [1:0] batt_decode(input logic first, input logic second);
      if (!first)
         batt_decode = BATT_DEAD;
      else if (!second)
         batt_decode = BATT_WEAK;
      else
         batt_decode = BATT_GOOD;
   endfunction

   // next values of the status flops
   always_comb begin
      // battery lines mean nothing in modem or I/O use of them
      batt_next = batt_decode(I_BATTERY_DETECT_FIRST, I_BATTERY_DETECT_SECOND);
      // ring is active low on the shared first line
      ring_next = I_MODEM_CARD & ~I_BATTERY_DETECT_FIRST;
      // speaker gated by I/O mode, merged with the other socket
      audio_next = (I_IO_MODE & I_BATTERY_DETECT_SECOND) ^ I_OTHER_AUDIO;
      cd1_next = I_CARD_DETECT_FIRST_N;
      cd2_next = I_CARD_DETECT_SECOND_N;
      present_next = ~I_CARD_DETECT_FIRST_N & ~I_CARD_DETECT_SECOND_N;
      // dma request from second battery line or input acknowledge
      if (I_DMA_REQ_SEL)
         dreq_next = ~I_INPUT_ACKNOWLEDGE_N;
      else
         dreq_next = I_BATTERY_DETECT_SECOND;
      iack_next = ~I_INPUT_ACKNOWLEDGE_N;
   end

   // status registers
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         batt_reg <= BATT_GOOD;
         ring_reg <= 1'b0;
         audio_reg <= 1'b0;
         cd1_reg <= 1'b1;
         cd2_reg <= 1'b1;
         present_reg <= 1'b0;
         dreq_reg <= 1'b0;
         iack_reg <= 1'b0;
      end else begin
         batt_reg <= batt_next;
         ring_reg <= ring_next;
         audio_reg <= audio_next;
         cd1_reg <= cd1_next;
         cd2_reg <= cd2_next;
         present_reg <= present_next;
         dreq_reg <= dreq_next;
         iack_reg <= iack_next;
      end
   end

   // -------------------------------------------------------------
   // strobe sequencer
   // -------------------------------------------------------------
   c16sc_state_t state_reg, state_next;  // sequencer state
   logic [CNT_W-1:0] cnt_reg, cnt_next;  // phase cycle count
   logic [1:0] kind_reg, kind_next;      // kind of cycle in flight
   logic ce_even_reg, ce_even_next;      // even byte enable, low active
   logic ce_odd_reg, ce_odd_next;        // odd byte enable, low active
   logic rd_reg, rd_next;                // read strobe, low active
   logic wr_reg, wr_next;                // write strobe, low active
   logic done_reg, done_next;            // end of cycle pulse
   logic busy_reg, busy_next;            // cycle in flight, registered for the port

   // the read strobe serves host reads and card-to-host dma
   function automatic logic is_read(input logic [1:0] kind);
      is_read = (kind == C16SC_IO_RD) || (kind == C16SC_DMA_C2H);
   endfunction

   // next state of the sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      kind_next = kind_reg;
      ce_even_next = ce_even_reg;
      ce_odd_next = ce_odd_reg;
      rd_next = 1'b1;
      wr_next = 1'b1;
      done_next = 1'b0;
      unique case (state_reg)
         C16SC_IDLE: begin
            // both strobes stay high between cycles
            ce_even_next = 1'b1;
            ce_odd_next = 1'b1;
            if (I_CYC_START) begin
               kind_next = I_CYC_KIND;
               // even byte on first enable, odd on second
               ce_even_next = I_CYC_ADDR0 & ~I_CYC_WIDE;
               ce_odd_next = ~I_CYC_ADDR0 & ~I_CYC_WIDE;
               cnt_next = CNT_W'(SETUP_CYC - 1);
               state_next = C16SC_SETUP;
            end
         end
         C16SC_SETUP: begin
            // address and enables settle before the strobe
            if (cnt_reg == '0) begin
               cnt_next = CNT_W'(STROBE_CYC - 1);
               rd_next = ~is_read(kind_reg);
               wr_next = is_read(kind_reg);
               state_next = C16SC_STROBE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         C16SC_STROBE: begin
            // only one strobe ever low
            rd_next = ~is_read(kind_reg);
            wr_next = is_read(kind_reg);
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 1'b1;
            end else if (I_WAIT_N) begin
               // wait released: release strobe
               rd_next = 1'b1;
               wr_next = 1'b1;
               cnt_next = CNT_W'(HOLD_CYC - 1);
               state_next = C16SC_HOLD;
            end
         end
         C16SC_HOLD: begin
            // enables held past the strobe edge
            if (cnt_reg == '0) begin
               ce_even_next = 1'b1;
               ce_odd_next = 1'b1;
               done_next = 1'b1;
               state_next = C16SC_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: begin
            state_next = C16SC_IDLE;
            ce_even_next = 1'b1;
            ce_odd_next = 1'b1;
         end
      endcase
      // busy follows the state about to be entered, so the flop matches the state
      busy_next = (state_next != C16SC_IDLE);
   end

   // sequencer registers
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_reg <= C16SC_IDLE;
         cnt_reg <= '0;
         kind_reg <= 2'h0;
         ce_even_reg <= 1'b1;
         ce_odd_reg <= 1'b1;
         rd_reg <= 1'b1;
         wr_reg <= 1'b1;
         done_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         kind_reg <= kind_next;
         ce_even_reg <= ce_even_next;
         ce_odd_reg <= ce_odd_next;
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         done_reg <= done_next;
         busy_reg <= busy_next;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign O_EVEN_BYTE_ENABLE_N = ce_even_reg;
   assign O_ODD_BYTE_ENABLE_N = ce_odd_reg;
   assign O_IO_READ_STROBE_N = rd_reg;
   assign O_IO_WRITE_STROBE_N = wr_reg;
   assign O_COMBINED_AUDIO_OUT = audio_reg;
   assign O_BATT_STATUS = batt_reg;
   assign O_RING_INDICATE = ring_reg;
   assign O_CARD_DETECT_FIRST_N = cd1_reg;
   assign O_CARD_DETECT_SECOND_N = cd2_reg;
   assign O_CARD_PRESENT = present_reg;
   assign O_DMA_REQ = dreq_reg;
   assign O_INPUT_ACK = iack_reg;
   assign O_CYC_BUSY = busy_reg;
   assign O_CYC_DONE = done_reg;
endmodule

// ### c16sc_pkg.sv
// Purpose: shared constants and types for the card socket control block
// Assumes: one 40 MHz clock, asynchronous active-low reset
// Notes: strobe timing counts are derived from times in nanoseconds
package c16sc_pkg;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;     // 40 MHz clock period
   localparam int STROBE_MIN_NS = 75;     // least strobe active time
   localparam int SETUP_MIN_NS = 25;      // least address setup before strobe
   localparam int HOLD_MIN_NS = 25;       // least hold after strobe
   // least times round up to whole cycles
   localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;              // width of the phase counter

   // -------------------------------------------------------------
   // battery condition codes
   // -------------------------------------------------------------
   localparam logic [1:0] BATT_GOOD = 2'h0; // both detect lines high
   localparam logic [1:0] BATT_WEAK = 2'h1; // second low, first high
   localparam logic [1:0] BATT_DEAD = 2'h2; // first low, data lost

   // -------------------------------------------------------------
   // cycle kinds and sequencer states
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      C16SC_IO_RD = 2'h0,    // host I/O read
      C16SC_IO_WR = 2'h1,    // host I/O write
      C16SC_DMA_C2H = 2'h2,  // dma card to host memory
      C16SC_DMA_H2C = 2'h3   // dma host memory to card
   } c16sc_kind_t;

   typedef enum logic [3:0] {
      C16SC_IDLE = 4'h1,
      C16SC_SETUP = 4'h2,
      C16SC_STROBE = 4'h4,
      C16SC_HOLD = 4'h8
   } c16sc_state_t;
endpackage

// ### c16sc_monitor.sv
// Purpose: port assertions for the card socket control block
// Assumes: bound to c16sc_socket_ctrl, one clock domain
// Notes: status outputs lag their inputs by one clock
`timescale 1ns/100ps
module c16sc_monitor
   import c16sc_pkg::*;
(
   // clock, reset and configuration
   input wire logic I_CLOCK, I_RST_N, I_IO_MODE, I_DMA_REQ_SEL, I_OTHER_AUDIO,
   // card side inputs
   input wire logic I_BATTERY_DETECT_FIRST, I_BATTERY_DETECT_SECOND,
   input wire logic I_INPUT_ACKNOWLEDGE_N, I_WAIT_N,
   // cycle request
   input wire logic I_CYC_START, I_CYC_ADDR0, I_CYC_WIDE,
   input wire logic [1:0] I_CYC_KIND,
   // watched outputs
   input wire logic O_EVEN_BYTE_ENABLE_N, O_ODD_BYTE_ENABLE_N, O_COMBINED_AUDIO_OUT,
   input wire logic O_IO_READ_STROBE_N, O_IO_WRITE_STROBE_N, O_DMA_REQ,
   input wire logic O_CYC_BUSY, O_CYC_DONE,
   input wire logic [1:0] O_BATT_STATUS
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);
   wire logic take = I_CYC_START && !O_CYC_BUSY; // request accepted this edge
   chk_strobe_excl: assert property (O_IO_READ_STROBE_N || O_IO_WRITE_STROBE_N)
      else $error("both strobes low");
   chk_idle_strobe: assert property (!O_CYC_BUSY |-> O_IO_READ_STROBE_N && O_IO_WRITE_STROBE_N)
      else $error("strobe low while idle");
   chk_batt_decode: assert property ($past(I_RST_N) |-> O_BATT_STATUS ==
      (!$past(I_BATTERY_DETECT_FIRST) ? BATT_DEAD :
      (!$past(I_BATTERY_DETECT_SECOND) ? BATT_WEAK : BATT_GOOD)))
      else $error("battery status wrong");
   chk_audio_mix: assert property ($past(I_RST_N) |-> O_COMBINED_AUDIO_OUT ==
      ($past(I_IO_MODE && I_BATTERY_DETECT_SECOND) ^ $past(I_OTHER_AUDIO)))
      else $error("combined audio wrong");
   chk_dma_source: assert property ($past(I_RST_N) |-> O_DMA_REQ ==
      ($past(I_DMA_REQ_SEL) ? !$past(I_INPUT_ACKNOWLEDGE_N) : $past(I_BATTERY_DETECT_SECOND)))
      else $error("dma request wrong");
   chk_read_strobe: assert property (take && !I_CYC_KIND[0] |-> ##2 !O_IO_READ_STROBE_N[*3])
      else $error("read strobe timing");
   chk_write_strobe: assert property (take && I_CYC_KIND[0] |->
      ##1 O_IO_WRITE_STROBE_N ##1 !O_IO_WRITE_STROBE_N[*3])
      else $error("write strobe timing");
   chk_even_enable: assert property (take && !I_CYC_WIDE && !I_CYC_ADDR0 |=>
      (!O_EVEN_BYTE_ENABLE_N && O_ODD_BYTE_ENABLE_N)[*5])
      else $error("even enable wrong");
   chk_odd_enable: assert property (take && !I_CYC_WIDE && I_CYC_ADDR0 |=>
      (O_EVEN_BYTE_ENABLE_N && !O_ODD_BYTE_ENABLE_N)[*5])
      else $error("odd enable wrong");
   chk_wait_hold: assert property (!O_IO_READ_STROBE_N && !I_WAIT_N |=> !O_IO_READ_STROBE_N)
      else $error("strobe ended during wait");
   chk_wait_hold_wr: assert property (!O_IO_WRITE_STROBE_N && !I_WAIT_N |=> !O_IO_WRITE_STROBE_N)
      else $error("write strobe ended during wait");
   chk_done_bound: assert property (take |-> ##[6:40] O_CYC_DONE)
      else $error("cycle never completed");
endmodule
bind c16sc_socket_ctrl c16sc_monitor i_mon (.*);

// ### c16sc_card_model.sv
// Purpose: behavioural 16-bit card at the socket's far side
// Assumes: runs on the controller clock
// Notes: wait is held for a set number of cycles after each strobe falls
`timescale 1ns/100ps
module c16sc_card_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // strobes from the controller
   input wire logic i_io_read_strobe_n,
   input wire logic i_io_write_strobe_n,
   // scenario controls
   input wire logic i_inserted,
   input wire logic i_dreq,
   input wire logic [1:0] i_batt,
   input wire logic [3:0] i_stall,
   // card lines
   output logic o_battery_detect_first,
   output logic o_battery_detect_second,
   output logic o_card_detect_first_n,
   output logic o_card_detect_second_n,
   output logic o_input_acknowledge_n,
   output logic o_wait_n
);
   logic [3:0] cnt; // wait cycles still to hold
   logic idle_q; // both strobes high one clock ago
   assign o_card_detect_first_n = !i_inserted;
   assign o_card_detect_second_n = !i_inserted;
   assign o_battery_detect_first = i_batt[0];
   assign o_battery_detect_second = i_batt[1] | i_dreq;
   assign o_input_acknowledge_n = !(i_dreq || !i_io_read_strobe_n);
   assign o_wait_n = (cnt == 4'h0);
   // start the wait count when a strobe falls
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= 4'h0;
         idle_q <= 1'b1;
      end else begin
         idle_q <= i_io_read_strobe_n & i_io_write_strobe_n;
         if (idle_q && !(i_io_read_strobe_n & i_io_write_strobe_n)) cnt <= i_stall;
         else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      end
   end
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for the card socket control block
// Assumes: card model on the far side, 40 MHz clock
// Notes: each scenario is its own task
`timescale 1ns/100ps
module tb_top;
   import c16sc_pkg::*;
   logic I_CLOCK = 1'b0, I_RST_N = 1'b0, io_mode = 1'b0, modem = 1'b0, dsel = 1'b0;
   logic other = 1'b0, start = 1'b0, addr0 = 1'b0, wide = 1'b0, inserted = 1'b1, dreq = 1'b0;
   logic [1:0] kind = 2'h0, batt = 2'h3;
   logic [3:0] stall = 4'h0;
   wire logic bf, bs, cd1, cd2, iack_n, wait_n, even_n, odd_n, rd_n, wr_n, aud, ring;
   wire logic cdo1, cdo2, pres, dmar, ack, busy, done;
   wire logic [1:0] bst;
   int bad_count = 0;
   int total_checks = 0;
   int hung = 0; // set when a cycle never completes
   always #12.5 I_CLOCK = ~I_CLOCK;
   c16sc_socket_ctrl i_dut (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_IO_MODE(io_mode),
      .I_MODEM_CARD(modem), .I_DMA_REQ_SEL(dsel), .I_BATTERY_DETECT_FIRST(bf),
      .I_BATTERY_DETECT_SECOND(bs), .I_CARD_DETECT_FIRST_N(cd1), .I_CARD_DETECT_SECOND_N(cd2),
      .I_INPUT_ACKNOWLEDGE_N(iack_n), .I_WAIT_N(wait_n), .I_OTHER_AUDIO(other),
      .I_CYC_START(start), .I_CYC_KIND(kind), .I_CYC_ADDR0(addr0), .I_CYC_WIDE(wide),
      .O_EVEN_BYTE_ENABLE_N(even_n), .O_ODD_BYTE_ENABLE_N(odd_n), .O_IO_READ_STROBE_N(rd_n),
      .O_IO_WRITE_STROBE_N(wr_n), .O_COMBINED_AUDIO_OUT(aud), .O_BATT_STATUS(bst),
      .O_RING_INDICATE(ring), .O_CARD_DETECT_FIRST_N(cdo1), .O_CARD_DETECT_SECOND_N(cdo2),
      .O_CARD_PRESENT(pres), .O_DMA_REQ(dmar), .O_INPUT_ACK(ack), .O_CYC_BUSY(busy),
      .O_CYC_DONE(done));
   c16sc_card_model i_card (.i_clk(I_CLOCK), .i_rst_n(I_RST_N), .i_io_read_strobe_n(rd_n),
      .i_io_write_strobe_n(wr_n), .i_inserted(inserted), .i_dreq(dreq), .i_batt(batt),
      .i_stall(stall), .o_battery_detect_first(bf), .o_battery_detect_second(bs),
      .o_card_detect_first_n(cd1), .o_card_detect_second_n(cd2),
      .o_input_acknowledge_n(iack_n), .o_wait_n(wait_n));
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge I_CLOCK);
      #1;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // battery decode and ring, modem flag toggled
   task automatic t_battery();
      logic [1:0] lines [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
      logic [1:0] exp [4] = '{BATT_GOOD, BATT_WEAK, BATT_DEAD, BATT_DEAD};
      for (int i = 0; i < 4; i++) begin
         @(posedge I_CLOCK);
         batt <= lines[i];
         modem <= i[0];
         tick();
         chk(bst, exp[i]);
         chk(ring, i[0] & !lines[i][0]);
      end
   endtask
   // audio combining over every input mix
   task automatic t_audio();
      for (int i = 0; i < 8; i++) begin
         @(posedge I_CLOCK);
         io_mode <= i[0];
         batt <= {i[1], 1'b1};
         other <= i[2];
         tick();
         chk(aud, (i[0] & i[1]) ^ i[2]);
      end
   endtask
   // insertion status and both dma request sources
   task automatic t_detect_dma();
      for (int i = 0; i < 4; i++) begin
         @(posedge I_CLOCK);
         batt <= 2'h1;
         inserted <= i[0];
         dsel <= i[1];
         dreq <= i[0];
         tick();
         chk({cdo1, cdo2, pres}, {!i[0], !i[0], i[0]});
         chk({dmar, ack}, {i[0], i[0]});
      end
      @(posedge I_CLOCK);
      dreq <= 1'b0;
      inserted <= 1'b1;
   endtask
   // one strobed cycle with optional card wait
   task automatic t_cycle(input logic [1:0] k, input logic a0, input logic w, input logic [3:0] st);
      int n = 0;
      int lo = 0;
      logic acked = 1'b0;
      @(posedge I_CLOCK);
      start <= 1'b1;
      kind <= k;
      addr0 <= a0;
      wide <= w;
      stall <= st;
      @(posedge I_CLOCK);
      start <= 1'b0;
      #1;
      chk({even_n, odd_n, busy}, {a0 & !w, !a0 & !w, 1'b1});
      while (done !== 1'b1 && n < 40) begin
         if ((k[0] ? wr_n : rd_n) === 1'b0) lo++;
         if (ack === 1'b1) acked = 1'b1;
         chk(rd_n | wr_n, 1'b1);
         tick();
         n++;
      end
      if (n >= 40) begin
         bad_count++;
         hung = 1;
         return;
      end
      chk(4'(lo), 4'(STROBE_CYC + ((st > 4'h1) ? st - 4'h1 : 4'h0)));
      chk(acked, !k[0]);
      chk({rd_n, wr_n, busy}, 3'h6);
   endtask
   initial begin
      repeat (20) @(posedge I_CLOCK);
      I_RST_N <= 1'b1;
      t_battery();
      t_audio();
      t_detect_dma();
      for (int i = 0; i < 16 && hung == 0; i++) begin
         t_cycle(i[1:0], i[2], i[3] & !i[2], {2'h0, i[3], 1'b0});
      end
      close_out();
   end
endmodule
